// ### mlbpi_port.sv
// Purpose: Pin stage of the media local bus port, 3-pin and 5-pin modes
// Assumes: Framing logic on sys_clk supplies per-bit-time drive requests
// Notes:   Pins change on the rising bus_bit_clock edge; inputs are
//          sampled on the same edge and handed back through synchronisers
`timescale 1ns/10ps

module mlbpi_port #(
  parameter int DEPTH = mlbpi_pkg::FIFO_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic                     busBitClock,
  input  wire logic                     portEnable,
  input  wire mlbpi_pkg::mlbpi_mode_type pinMode,
  input  wire mlbpi_pkg::mlbpi_bits_type txBits,
  input  wire mlbpi_pkg::mlbpi_own_type  txOwn,
  input  wire logic                     txValid,
  output logic                          txReady,
  output mlbpi_pkg::mlbpi_bits_type     rxBits,
  output logic                          rxValid,
  input  wire logic                     sharedDataLineIn,
  output logic                          sharedDataLineOut,
  output logic                          sharedDataLineOe,
  input  wire logic                     sharedSignalLineIn,
  output logic                          sharedSignalLineOut,
  output logic                          sharedSignalLineOe,
  output logic                          dataOutputPin,
  output logic                          dataOutputPinOe,
  output logic                          signalOutputPin,
  output logic                          signalOutputPinOe
);
  localparam int W = 2 * mlbpi_pkg::FIFO_WIDTH;

  // Link-domain reset, released synchronously to the bus clock
  logic linkRstS1_q, linkRst_bq;
  always_ff @(posedge busBitClock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      linkRstS1_q <= 1'h0;
      linkRst_bq  <= 1'h0;
    end
    else
    begin
      linkRstS1_q <= 1'h1;
      linkRst_bq  <= linkRstS1_q;
    end
  end

  // Config levels cross into the link domain on two flops each
  logic [1:0] cfgS1_q, cfgS2_q;
  always_ff @(posedge busBitClock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfgS1_q <= 2'h0;
      cfgS2_q <= 2'h0;
    end
    else
    begin
      cfgS1_q <= {portEnable, pinMode == mlbpi_pkg::MLBPI_MODE_FIVE};
      cfgS2_q <= cfgS1_q;
    end
  end

  logic linkEn, linkFive;
  assign linkEn   = cfgS2_q[1];
  assign linkFive = cfgS2_q[0];

  // Outgoing bit times cross through the FIFO to the bus clock
  logic [W-1:0] fifoOut;
  logic         fifoValid;
  mlbpi_fifo #(.WIDTH(W), .DEPTH(DEPTH)) uTxFifo (
    .wrClk   (sys_clk),
    .wrRst_b (rst_b),
    .wrData  ({txOwn, txBits}),
    .wrValid (txValid),
    .wrReady (txReady),
    .rdClk   (busBitClock),
    .rdRst_b (linkRst_bq),
    .rdData  (fifoOut),
    .rdValid (fifoValid),
    .rdReady (linkEn)
  );

  mlbpi_pkg::mlbpi_own_type  curOwn;
  mlbpi_pkg::mlbpi_bits_type curBits;
  always_comb
  begin
    // Underrun means no slot of ours: release every lane
    curOwn  = mlbpi_pkg::mlbpi_own_type'(fifoValid ? fifoOut[W-1:2]
                                                   : mlbpi_pkg::PINS_RESET);
    curBits = mlbpi_pkg::mlbpi_bits_type'(fifoOut[1:0]);
  end

  // Pin drive state, all on the controller's bus clock
  logic [1:0] bitVal_d, bitVal_q;
  logic [3:0] oe_d, oe_q;
  always_comb
  begin
    bitVal_d = curBits;
    oe_d     = 4'h0;
    if (linkEn)
    begin
      if (linkFive)
      begin
        oe_d[2] = curOwn.dataOwn;
        oe_d[3] = curOwn.signalOwn;
      end
      else
      begin
        oe_d[0] = curOwn.dataOwn;
        oe_d[1] = curOwn.signalOwn;
      end
    end
  end

  always_ff @(posedge busBitClock or negedge linkRst_bq)
  begin
    if (!linkRst_bq)
    begin
      bitVal_q <= mlbpi_pkg::PINS_RESET;
      oe_q     <= 4'h0;
    end
    else
    begin
      bitVal_q <= bitVal_d;
      oe_q     <= oe_d;
    end
  end

  assign sharedDataLineOut   = bitVal_q[1];
  assign sharedSignalLineOut = bitVal_q[0];
  assign dataOutputPin       = bitVal_q[1];
  assign signalOutputPin     = bitVal_q[0];
  assign sharedDataLineOe    = oe_q[0];
  assign sharedSignalLineOe  = oe_q[1];
  assign dataOutputPinOe     = oe_q[2];
  assign signalOutputPinOe   = oe_q[3];

  // Receive: sample pins on bus clock, hand each sample over by toggle
  logic [1:0] rxHold_q, rxHold_d;
  logic       rxReq_q, rxReq_d;
  logic       rxAckS1_q, rxAckS2_q;
  logic       rxSeen_q;
  logic       rxTake;

  // Hold reloads only once sys_clk acknowledged the previous sample
  assign rxTake = linkEn && (rxReq_q == rxAckS2_q);

  always_comb
  begin
    rxHold_d = rxTake ? {sharedDataLineIn, sharedSignalLineIn} : rxHold_q;
    rxReq_d  = rxTake ? ~rxReq_q : rxReq_q;
  end

  always_ff @(posedge busBitClock or negedge linkRst_bq)
  begin
    if (!linkRst_bq)
    begin
      rxHold_q  <= 2'h0;
      rxReq_q   <= 1'h0;
      rxAckS1_q <= 1'h0;
      rxAckS2_q <= 1'h0;
    end
    else
    begin
      rxHold_q  <= rxHold_d;
      rxReq_q   <= rxReq_d;
      rxAckS1_q <= rxSeen_q;
      rxAckS2_q <= rxAckS1_q;
    end
  end

  // Lossy by design: pins keep moving while a sample is in flight,
  // so only a fraction of bit times reaches sys_clk (monitor use only)
  logic       rxReqS1_q, rxReqS2_q;
  logic [1:0] rxOut_q, rxOut_d;
  logic       rxVal_q, rxVal_d;
  always_comb
  begin
    rxVal_d = rxReqS2_q != rxSeen_q;
    rxOut_d = rxVal_d ? rxHold_q : rxOut_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxReqS1_q <= 1'h0;
      rxReqS2_q <= 1'h0;
      rxSeen_q  <= 1'h0;
      rxOut_q   <= 2'h0;
      rxVal_q   <= 1'h0;
    end
    else
    begin
      rxReqS1_q <= rxReq_q;
      rxReqS2_q <= rxReqS1_q;
      rxSeen_q  <= rxReqS2_q;
      rxOut_q   <= rxOut_d;
      rxVal_q   <= rxVal_d;
    end
  end

  assign rxBits  = rxOut_q;
  assign rxValid = rxVal_q;

  // Checks on the link-domain pin drivers and the receive handover
  sequence fiveCfg_s;
    linkEn && linkFive;
  endsequence

  sequence threeCfg_s;
    linkEn && !linkFive;
  endsequence

  property noSharedInFive_p;
    @(posedge busBitClock) disable iff (!linkRst_bq)
      fiveCfg_s |=> !sharedDataLineOe && !sharedSignalLineOe;
  endproperty

  property noDedicatedInThree_p;
    @(posedge busBitClock) disable iff (!linkRst_bq)
      threeCfg_s |=> !dataOutputPinOe && !signalOutputPinOe;
  endproperty

  shared_data_five_a: assert property (noSharedInFive_p)
    else $error("shared line driven in 5-pin mode");
  shared_sig_five_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    linkFive |=> !sharedSignalLineOe)
    else $error("shared signal line driven in 5-pin mode");
  dedicated_data_a: assert property (noDedicatedInThree_p)
    else $error("dedicated pin driven in 3-pin mode");
  dedicated_sig_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    !linkFive |=> !signalOutputPinOe)
    else $error("signal output pin driven in 3-pin mode");
  idle_release_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    !fifoValid |=> oe_q == 4'h0)
    else $error("pin driven without a slot");
  disabled_hiz_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    !linkEn |=> oe_q == 4'h0)
    else $error("pin driven while port unconfigured");
  slot_data_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    threeCfg_s ##0 (fifoValid && curOwn.dataOwn) |=> sharedDataLineOe
      && sharedDataLineOut == $past(curBits.dataBit))
    else $error("owned data slot not driven");
  slot_signal_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    fiveCfg_s ##0 (fifoValid && curOwn.signalOwn) |=> signalOutputPinOe
      && signalOutputPin == $past(curBits.signalBit))
    else $error("owned signal slot not driven");
  reset_hiz_a: assert property (@(posedge sys_clk)
    !rst_b |-> oe_q == 4'h0)
    else $error("pin driven during reset");
  rx_toggle_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    linkEn && rxReq_q == rxAckS2_q |=> rxReq_q != $past(rxReq_q))
    else $error("receive sample not taken when handover idle");
  rx_hold_a: assert property (@(posedge busBitClock) disable iff (!linkRst_bq)
    rxReq_q != rxAckS2_q |=> $stable(rxHold_q))
    else $error("receive sample changed before handover");
endmodule

// ### mlbpi_pkg.sv
// Purpose: Shared constants and carriers for the media local bus pin port
// Assumes: Bit-level framing is handled by logic outside this port
// Notes:   Pin mode and enable come in as plain inputs, synchronised on two flops each
package mlbpi_pkg;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] PINS_RESET = 2'h0;
  localparam logic CONFIG_RESET = 1'h0;

  typedef enum logic {
    MLBPI_MODE_THREE,
    MLBPI_MODE_FIVE
  } mlbpi_mode_type;

  // One bit time worth of outgoing traffic
  typedef struct packed {
    logic dataBit;
    logic signalBit;
  } mlbpi_bits_type;

  // Drive request for one bit time: which lanes are ours to drive
  typedef struct packed {
    logic dataOwn;
    logic signalOwn;
  } mlbpi_own_type;

endpackage

// ### mlbpi_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides, two clocks
// Assumes: Write side on wrClk, read side on rdClk, gray pointers cross
// Notes:   Depth must be a power of two
`timescale 1ns/10ps
module mlbpi_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input  wire logic             wrClk,
  input  wire logic             wrRst_b,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic             rdClk,
  input  wire logic             rdRst_b,
  output logic [WIDTH-1:0]      rdData,
  output logic                  rdValid,
  input  wire logic             rdReady
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      wrGray_q, rdGray_q;
  logic [AW:0]      rdGrayS1_q, rdGrayS2_q, wrGrayS1_q, wrGrayS2_q;
  logic             push, pop;

  assign wrReady = wrGray_q != {~rdGrayS2_q[AW:AW-1], rdGrayS2_q[AW-2:0]};
  assign rdValid = rdGray_q != wrGrayS2_q;
  assign rdData  = mem_q[rdPtr_q[AW-1:0]];
  assign push    = wrValid && wrReady;
  assign pop     = rdValid && rdReady;

  always_comb
  begin
    wrPtr_d = wrPtr_q + (AW+1)'(push);
    rdPtr_d = rdPtr_q + (AW+1)'(pop);
  end

  always_ff @(posedge wrClk)
  begin
    if (push)
      mem_q[wrPtr_q[AW-1:0]] <= wrData;
  end

  always_ff @(posedge wrClk or negedge wrRst_b)
  begin
    if (!wrRst_b)
    begin
      wrPtr_q    <= '0;
      wrGray_q   <= '0;
      rdGrayS1_q <= '0;
      rdGrayS2_q <= '0;
    end
    else
    begin
      wrPtr_q    <= wrPtr_d;
      wrGray_q   <= toGray(wrPtr_d);
      rdGrayS1_q <= rdGray_q;
      rdGrayS2_q <= rdGrayS1_q;
    end
  end

  always_ff @(posedge rdClk or negedge rdRst_b)
  begin
    if (!rdRst_b)
    begin
      rdPtr_q    <= '0;
      rdGray_q   <= '0;
      wrGrayS1_q <= '0;
      wrGrayS2_q <= '0;
    end
    else
    begin
      rdPtr_q    <= rdPtr_d;
      rdGray_q   <= toGray(rdPtr_d);
      wrGrayS1_q <= wrGray_q;
      wrGrayS2_q <= wrGrayS1_q;
    end
  end
endmodule

// ### mlbpi_bus_ctrl_model.sv
// Purpose: Far-side model: bus controller making the bit clock
// Assumes: Bench says when the controller owns the shared lanes
// Notes:   Undriven lanes toggle every bit time, never hold a value
`timescale 1ns/10ps
module mlbpi_bus_ctrl_model (
  output logic                      busBitClock,
  input  wire logic                 devDataOe,
  input  wire logic                 devDataOut,
  input  wire logic                 devSigOe,
  input  wire logic                 devSigOut,
  input  wire logic                 ctrlDrive,
  input  wire mlbpi_pkg::mlbpi_bits_type ctrlVal,
  output logic                      dataLine,
  output logic                      sigLine,
  output logic                      clash
);
  logic idleBit = 1'b0;
  initial
  begin
    busBitClock = 1'b0;
    #3;
    forever #6 busBitClock = ~busBitClock;
  end
  always @(posedge busBitClock) idleBit <= ~idleBit;
  // Controller yields to the transmitter, flags any overlap
  assign dataLine = devDataOe ? devDataOut : (ctrlDrive ? ctrlVal.dataBit : idleBit);
  assign sigLine = devSigOe ? devSigOut : (ctrlDrive ? ctrlVal.signalBit : ~idleBit);
  assign clash = ctrlDrive & (devDataOe | devSigOe);
endmodule

// ### test_media_local_bus_pin_interface.sv
// Purpose: Self-checking bench for the media local bus pin stage
// Assumes: Partner model makes the bit clock and far-side drive
// Notes:   Lane activity is logged per bit time, compared in order
`timescale 1ns/10ps
`define CHECK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_media_local_bus_pin_interface;
  logic sys_clk, rst_b, busBitClock, portEnable, txValid, txReady, rxValid, ctrlDrive;
  logic sdIn, sdOut, sdOe, ssIn, ssOut, ssOe, doPin, doOe, soPin, soOe, clash, quiet;
  mlbpi_pkg::mlbpi_mode_type pinMode;
  mlbpi_pkg::mlbpi_bits_type txBits, rxBits, ctrlVal;
  mlbpi_pkg::mlbpi_own_type  txOwn;
  logic [3:0] pinsNow;
  logic [3:0] seen[$];
  logic [3:0] expQ[$];
  int bad_count = 0;
  int checks_done = 0;

  mlbpi_port DUT (.sys_clk(sys_clk), .rst_b(rst_b), .busBitClock(busBitClock),
    .portEnable(portEnable), .pinMode(pinMode), .txBits(txBits), .txOwn(txOwn),
    .txValid(txValid), .txReady(txReady), .rxBits(rxBits), .rxValid(rxValid),
    .sharedDataLineIn(sdIn), .sharedDataLineOut(sdOut), .sharedDataLineOe(sdOe),
    .sharedSignalLineIn(ssIn), .sharedSignalLineOut(ssOut), .sharedSignalLineOe(ssOe),
    .dataOutputPin(doPin), .dataOutputPinOe(doOe), .signalOutputPin(soPin),
    .signalOutputPinOe(soOe));
  mlbpi_bus_ctrl_model PEER (.busBitClock(busBitClock), .devDataOe(sdOe),
    .devDataOut(sdOut), .devSigOe(ssOe), .devSigOut(ssOut), .ctrlDrive(ctrlDrive),
    .ctrlVal(ctrlVal), .dataLine(sdIn), .sigLine(ssIn), .clash(clash));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge busBitClock)
  begin
    if (pinMode == mlbpi_pkg::MLBPI_MODE_THREE)
    begin
      pinsNow = {sdOe, sdOe & sdOut, ssOe, ssOe & ssOut};
      `CHECK("dedicated oe", 1'b0, doOe | soOe)
    end
    else
    begin
      pinsNow = {doOe, doOe & doPin, soOe, soOe & soPin};
      `CHECK("shared oe", 1'b0, sdOe | ssOe)
    end
    if (quiet)
      `CHECK("idle oe", 1'b0, sdOe | ssOe | doOe | soOe)
    `CHECK("lane clash", 1'b0, clash)
    if (pinsNow[3] | pinsNow[1])
      seen.push_back(pinsNow);
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Called at a falling edge; valid stays up for back-to-back pushes
  task automatic push(input logic [1:0] b, input logic [1:0] o);
    txBits = mlbpi_pkg::mlbpi_bits_type'(b);
    txOwn = mlbpi_pkg::mlbpi_own_type'(o);
    txValid = 1'b1;
    // Ready only moves on a rising edge, so judge it at the falling one
    while (txReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    expQ.push_back({o[1], o[1] & b[1], o[0], o[0] & b[0]});
  endtask

  task automatic drain_check(input string nm);
    int n;
    txValid = 1'b0;
    for (n = 0; n < 200 && seen.size() < expQ.size(); n++) @(negedge sys_clk);
    repeat (10) @(negedge sys_clk);
    `CHECK("lane count", expQ.size(), seen.size())
    for (n = 0; n < expQ.size() && n < seen.size(); n++)
      `CHECK("lane bits", expQ[n], seen[n])
    seen.delete();
    expQ.delete();
    $display("test %s done", nm);
  endtask

  task automatic reset_phase();
    rst_b = 1'b0;
    repeat (10) @(negedge sys_clk);
    `CHECK("oe in reset", 4'h0, {sdOe, ssOe, doOe, soOe})
    `CHECK("ready in reset", 1'b1, txReady)
    `CHECK("rx in reset", 1'b0, rxValid)
    rst_b = 1'b1;
    $display("test reset done");
  endtask

  task automatic tx_mode(input mlbpi_pkg::mlbpi_mode_type m, input string nm);
    pinMode = m;
    portEnable = 1'b1;
    quiet = 1'b0;
    repeat (8) @(negedge sys_clk);
    push(2'h2, 2'h3);
    push(2'h1, 2'h3);
    push(2'h3, 2'h2);
    push(2'h1, 2'h1);
    drain_check(nm);
  endtask

  task automatic fill_drain();
    int n;
    portEnable = 1'b0;
    repeat (8) @(negedge sys_clk);
    quiet = 1'b1;
    for (n = 0; n < 16; n++)
      push(n[1:0], 2'(3 - n[2:1] % 3));
    `CHECK("ready when full", 1'b0, txReady)
    quiet = 1'b0;
    portEnable = 1'b1;
    drain_check("fill");
  endtask

  task automatic rx_sample();
    int n;
    int k;
    ctrlDrive = 1'b1;
    for (n = 0; n < 4; n++)
    begin
      ctrlVal = mlbpi_pkg::mlbpi_bits_type'(n[1:0]);
      repeat (6) @(negedge sys_clk);
      for (k = 0; k < 20 && rxValid !== 1'b1; k++) @(negedge sys_clk);
      `CHECK("rx bits", n[1:0], rxBits)
    end
    ctrlDrive = 1'b0;
    $display("test rx done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    portEnable = 1'b0;
    pinMode = mlbpi_pkg::MLBPI_MODE_THREE;
    txBits = '0;
    txOwn = '0;
    txValid = 1'b0;
    ctrlDrive = 1'b0;
    ctrlVal = '0;
    quiet = 1'b1;
    @(negedge sys_clk);
    reset_phase();
    tx_mode(mlbpi_pkg::MLBPI_MODE_THREE, "three");
    tx_mode(mlbpi_pkg::MLBPI_MODE_FIVE, "five");
    fill_drain();
    rx_sample();
    stop_test();
  end

  initial
  begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule
